// [rtl/rtcam_regs.sv]
// timekeeping register map, calendar update and the two alarms
// Operation
// - alarm one set by writes to 07h-0Ah
// - alarm two set by writes 0Bh-0Dh
// - bit 7 of alarm bytes masks field
// - no masks: all compared fields must match
// - bit 6 selects weekday or date
// - select zero compares date of month
// - select one compares weekday, hours, minutes, seconds
// - alarm one mask patterns set repeat rate
// - alarm two all masked: every minute
// - alarm two mask patterns set repeat rate
// - match sets flag regardless of enables
// - pin needs irq enable and irq select
// - compare only at once-per-second update
// - unspecified registers need no power-up value
// - time and alarm fields kept in bcd
// - pointer wraps from 12h to 00h
// - hours bit 6 twelve-hour, bit 5 pm
// - addresses 14h-FFh are general storage
`timescale 1ns/1ps
module rtcam_regs
	import rtcam_pkg::*;
(
	// clock, reset and enable
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// one hertz square wave from the oscillator chain
	input  wire logic       osc_wave,
	// register port behind the serial engine
	input  wire logic       ptr_load,
	input  wire logic [7:0] ptr_value,
	input  wire logic       wr_strobe,
	input  wire logic [7:0] wr_data,
	input  wire logic       rd_strobe,
	output logic      [7:0] rd_data,
	output logic            rd_valid,
	// temperature result from the sensor logic
	input  wire logic [7:0] temp_high,
	input  wire logic [7:0] temp_low,
	// open-drain interrupt or wave pin, low when driven
	output logic            irq_wave_o,
	output logic            irq_wave_oe
);

	// ********************************************************
	// storage
	// ********************************************************
	logic [7:0] seconds_count;      // bcd seconds
	logic [7:0] minutes_count;      // bcd minutes
	logic [7:0] hours_count;        // mode, pm/20, bcd hours
	logic [7:0] weekday_count;      // 1 to 7
	logic [7:0] month_day_count;    // bcd date
	logic [7:0] month_and_century;  // century bit and bcd month
	logic [7:0] year_count;         // bcd year
	logic [7:0] alarm_one_seconds;  // alarm one bytes
	logic [7:0] alarm_one_minutes;
	logic [7:0] alarm_one_hours;
	logic [7:0] alarm_one_day_date;
	logic [7:0] alarm_two_minutes;  // alarm two bytes
	logic [7:0] alarm_two_hours;
	logic [7:0] alarm_two_day_date;
	logic [7:0] control;            // enables and pin select
	logic [7:0] status;             // flags
	logic [7:0] frequency_trim;     // stored only
	logic [7:0] test_soft_reset;    // stored only
	logic [7:0] user_ram [SRAM_BASE:8'hff]; // general storage
	logic [7:0] ptr;                // register pointer
	logic       wave_last;          // osc_wave one cycle ago

	// ********************************************************
	// update helpers
	// ********************************************************
	// bcd increment, low digit 9 carries into the tens
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == BCD_NINE) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_inc

	// last date of a month; leap test works on the bcd year
	function automatic logic [7:0] month_end(input logic [7:0] mon,
		input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
			yr[3:0] == 4'h8);
		case (mon)
			MON_FEB: month_end = leap ? DAYS_29 : DAYS_28;
			MON_APR, MON_JUN, MON_SEP, MON_NOV: month_end = DAYS_30;
			default: month_end = DAYS_31;
		endcase
	endfunction : month_end

	// ********************************************************
	// once-per-second calendar step
	// ********************************************************
	logic       sec_tick;        // rising edge of the wave
	logic       wr_go;           // write accepted this cycle
	logic       rd_go;           // read accepted this cycle
	logic [7:0] next_seconds;
	logic [7:0] next_minutes;
	logic [7:0] next_hours;
	logic [7:0] next_weekday;
	logic [7:0] next_month_day;
	logic [7:0] next_month_cen;
	logic [7:0] next_year;
	logic       day_carry;       // midnight passed

	assign sec_tick = ce && osc_wave && !wave_last;
	assign wr_go    = ce && wr_strobe && !ptr_load;
	assign rd_go    = ce && rd_strobe && !ptr_load;

	// carries ripple only when every lower field is at its last value
	always_comb begin
		next_seconds   = bcd_inc(seconds_count);
		next_minutes   = minutes_count;
		next_hours     = hours_count;
		next_weekday   = weekday_count;
		next_month_day = month_day_count;
		next_month_cen = month_and_century;
		next_year      = year_count;
		day_carry      = 1'b0;
		if (seconds_count == SEC_LAST) begin
			next_seconds = BCD_ZERO;
			next_minutes = bcd_inc(minutes_count);
			if (minutes_count == SEC_LAST) begin
				next_minutes = BCD_ZERO;
				if (hours_count[MODE12_BIT]) begin
					// 11 rolls to 12 and flips pm; 11 pm ends the day
					if (hours_count[4:0] == H12_ELEVEN[4:0]) begin
						next_hours = {hours_count[7:6],
							!hours_count[PM_BIT], H12_TWELVE[4:0]};
						day_carry  = hours_count[PM_BIT];
					end else if (hours_count[4:0] == H12_TWELVE[4:0]) begin
						next_hours = {hours_count[7:5], BCD_ONE[4:0]};
					end else begin
						next_hours = {hours_count[7:5],
							5'(bcd_inc({3'h0, hours_count[4:0]}))};
					end
				end else if (hours_count[5:0] == H24_LAST[5:0]) begin
					next_hours = {hours_count[7:6], 6'h00};
					day_carry  = 1'b1;
				end else begin
					next_hours = {hours_count[7:6],
						6'(bcd_inc({2'h0, hours_count[5:0]}))};
				end
			end
		end
		// weekday, date, month, year and century at midnight
		if (day_carry) begin
			next_weekday = (weekday_count == WEEKDAY_LAST) ? BCD_ONE
				: bcd_inc(weekday_count);
			next_month_day = bcd_inc(month_day_count);
			if (month_day_count == month_end({3'h0,
				month_and_century[4:0]}, year_count)) begin
				next_month_day = BCD_ONE;
				next_month_cen = {month_and_century[7:5],
					5'(bcd_inc({3'h0, month_and_century[4:0]}))};
				if (month_and_century[4:0] == MONTH_LAST[4:0]) begin
					next_month_cen = {month_and_century[7:5],
						BCD_ONE[4:0]};
					next_year = bcd_inc(year_count);
					if (year_count == YEAR_LAST) begin
						next_year = BCD_ZERO;
						next_month_cen[CENTURY_BIT] =
							!month_and_century[CENTURY_BIT];
					end
				end
			end
		end
	end

	// ********************************************************
	// alarm compare against the stepped time
	// ********************************************************
	logic a1_hit; // alarm one fields equal
	logic a2_hit; // alarm two fields equal

	rtcam_alarm_match u_alarm_one (
		.alarm_seconds  (alarm_one_seconds),
		.alarm_minutes  (alarm_one_minutes),
		.alarm_hours    (alarm_one_hours),
		.alarm_day_date (alarm_one_day_date),
		.now_seconds    (next_seconds),
		.now_minutes    (next_minutes),
		.now_hours      (next_hours),
		.now_weekday    (next_weekday),
		.now_month_day  (next_month_day),
		.hit            (a1_hit)
	);

	// no seconds byte: an unmasked zero makes it fire at second 00
	rtcam_alarm_match u_alarm_two (
		.alarm_seconds  (BCD_ZERO),
		.alarm_minutes  (alarm_two_minutes),
		.alarm_hours    (alarm_two_hours),
		.alarm_day_date (alarm_two_day_date),
		.now_seconds    (next_seconds),
		.now_minutes    (next_minutes),
		.now_hours      (next_hours),
		.now_weekday    (next_weekday),
		.now_month_day  (next_month_day),
		.hit            (a2_hit)
	);

	// ********************************************************
	// pointer and edge detect
	// ********************************************************
	// the wave is produced on this clock, so no synchroniser
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wave_last <= 1'b0;
		end else if (ce) begin
			wave_last <= osc_wave;
		end
	end

	// load wins; each access steps, 12h wraps and ffh rolls over
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ptr <= CLEAR_RST;
		end else if (ce && ptr_load) begin
			ptr <= ptr_value;
		end else if (wr_go || rd_go) begin
			ptr <= (ptr == PTR_WRAP) ? REG_SECONDS
				: ptr + 8'h01;
		end
	end

	// ********************************************************
	// time registers: host write beats the step
	// ********************************************************
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			seconds_count     <= CLEAR_RST;
			minutes_count     <= CLEAR_RST;
			hours_count       <= HOURS_RST;
			weekday_count     <= BCD_ONE;
			month_day_count   <= BCD_ONE;
			month_and_century <= BCD_ONE;
			year_count        <= CLEAR_RST;
		end else begin
			if (sec_tick) begin
				seconds_count     <= next_seconds;
				minutes_count     <= next_minutes;
				hours_count       <= next_hours;
				weekday_count     <= next_weekday;
				month_day_count   <= next_month_day;
				month_and_century <= next_month_cen;
				year_count        <= next_year;
			end
			if (wr_go) begin
				case (ptr)
					REG_SECONDS:   seconds_count     <= wr_data;
					REG_MINUTES:   minutes_count     <= wr_data;
					REG_HOURS:     hours_count       <= wr_data;
					REG_WEEKDAY:   weekday_count     <= wr_data;
					REG_MONTH_DAY: month_day_count   <= wr_data;
					REG_MONTH_CEN: month_and_century <= wr_data;
					REG_YEAR:      year_count        <= wr_data;
					default: ;
				endcase
			end
		end
	end

	// ********************************************************
	// alarm and setup registers
	// ********************************************************
	// reset values are ours; software is expected to program them
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			alarm_one_seconds  <= CLEAR_RST;
			alarm_one_minutes  <= CLEAR_RST;
			alarm_one_hours    <= CLEAR_RST;
			alarm_one_day_date <= CLEAR_RST;
			alarm_two_minutes  <= CLEAR_RST;
			alarm_two_hours    <= CLEAR_RST;
			alarm_two_day_date <= CLEAR_RST;
			control            <= CONTROL_RST;
			frequency_trim     <= CLEAR_RST;
			test_soft_reset    <= CLEAR_RST;
		end else if (wr_go) begin
			case (ptr)
				REG_A1_SEC:  alarm_one_seconds  <= wr_data;
				REG_A1_MIN:  alarm_one_minutes  <= wr_data;
				REG_A1_HOUR: alarm_one_hours    <= wr_data;
				REG_A1_DAY:  alarm_one_day_date <= wr_data;
				REG_A2_MIN:  alarm_two_minutes  <= wr_data;
				REG_A2_HOUR: alarm_two_hours    <= wr_data;
				REG_A2_DAY:  alarm_two_day_date <= wr_data;
				REG_CONTROL: control            <= wr_data;
				REG_TRIM:    frequency_trim     <= wr_data;
				REG_TEST:    test_soft_reset    <= wr_data & TEST_KEEP;
				// temperature bytes are not stored here at all
				default: ;
			endcase
		end
	end

	// general storage above the map, not reset
	always_ff @(posedge clock) begin
		if (wr_go && ptr >= SRAM_BASE) begin
			user_ram[ptr] <= wr_data;
		end
	end

	// ********************************************************
	// status: flags set by a match, cleared by writing zero
	// ********************************************************
	// a match in the clearing cycle wins over the clear
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			status <= STATUS_RST;
		end else if (ce) begin
			if (wr_go && ptr == REG_STATUS) begin
				status <= (wr_data & STAT_KEEP) |
					({8{wr_data[STAT_OSC]}} & status &
					(8'h01 << STAT_OSC)) |
					(wr_data & status & 8'h03);
			end
			if (sec_tick && a1_hit) begin
				status[STAT_A1_FLAG] <= 1'b1;
			end
			if (sec_tick && a2_hit) begin
				status[STAT_A2_FLAG] <= 1'b1;
			end
		end
	end

	// ********************************************************
	// read port
	// ********************************************************
	logic [7:0] next_rd_data; // byte at the pointer

	always_comb begin
		case (ptr)
			REG_SECONDS:   next_rd_data = seconds_count;
			REG_MINUTES:   next_rd_data = minutes_count;
			REG_HOURS:     next_rd_data = hours_count;
			REG_WEEKDAY:   next_rd_data = weekday_count;
			REG_MONTH_DAY: next_rd_data = month_day_count;
			REG_MONTH_CEN: next_rd_data = month_and_century;
			REG_YEAR:      next_rd_data = year_count;
			REG_A1_SEC:    next_rd_data = alarm_one_seconds;
			REG_A1_MIN:    next_rd_data = alarm_one_minutes;
			REG_A1_HOUR:   next_rd_data = alarm_one_hours;
			REG_A1_DAY:    next_rd_data = alarm_one_day_date;
			REG_A2_MIN:    next_rd_data = alarm_two_minutes;
			REG_A2_HOUR:   next_rd_data = alarm_two_hours;
			REG_A2_DAY:    next_rd_data = alarm_two_day_date;
			REG_CONTROL:   next_rd_data = control;
			REG_STATUS:    next_rd_data = status;
			REG_TRIM:      next_rd_data = frequency_trim;
			REG_TEMP_HIGH: next_rd_data = temp_high;
			REG_TEMP_LOW:  next_rd_data = temp_low & TEMP_LOW_KEEP;
			REG_TEST:      next_rd_data = test_soft_reset;
			default:       next_rd_data = user_ram[ptr];
		endcase
	end

	// valid stands for one cycle after the read strobe; data holds until the next read
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_data  <= CLEAR_RST;
			rd_valid <= 1'b0;
		end else if (ce) begin
			rd_valid <= rd_go;
			if (rd_go) begin
				rd_data <= next_rd_data;
			end
		end
	end

	// ********************************************************
	// interrupt or wave pin
	// ********************************************************
	// pin is pulled low only, so the data output stays zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_wave_o  <= 1'b0;
			irq_wave_oe <= 1'b0;
		end else if (ce) begin
			irq_wave_o <= 1'b0;
			if (control[CTRL_NOTWAVE]) begin
				irq_wave_oe <= (status[STAT_A1_FLAG] &&
					control[CTRL_A1_IE]) || (status[STAT_A2_FLAG] &&
					control[CTRL_A2_IE]);
			end else begin
				irq_wave_oe <= !osc_wave;
			end
		end
	end

	// ********************************************************
	// checks
	// ********************************************************
	a_flag_one_set: assert property (@(posedge clock) disable iff (!rst_n)
		sec_tick && a1_hit |=> status[STAT_A1_FLAG])
		else $error("alarm one match did not set its flag");
	a_pin_needs_enable: assert property (@(posedge clock)
		disable iff (!rst_n) ce && control[CTRL_NOTWAVE] &&
		!(status[STAT_A1_FLAG] && control[CTRL_A1_IE]) &&
		!(status[STAT_A2_FLAG] && control[CTRL_A2_IE])
		|=> !irq_wave_oe)
		else $error("pin driven without an enabled flag");
	a_flag_only_tick: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(status[STAT_A2_FLAG]) |-> $past(sec_tick))
		else $error("alarm two flag rose off the second update");
	a_pointer_wraps: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_go || rd_go) && ptr == PTR_WRAP |=> ptr == REG_SECONDS)
		else $error("pointer did not wrap to zero");
	a_temp_read_only: assert property (@(posedge clock)
		disable iff (!rst_n) rd_go && ptr == REG_TEMP_HIGH
		|=> rd_valid && rd_data == $past(temp_high))
		else $error("temperature read returned stored data");
	a_every_second: assert property (@(posedge clock) disable iff (!rst_n)
		sec_tick && (&{alarm_one_seconds[MASK_BIT],
		alarm_one_minutes[MASK_BIT], alarm_one_hours[MASK_BIT],
		alarm_one_day_date[MASK_BIT]}) |=> status[STAT_A1_FLAG])
		else $error("fully masked alarm one missed a second");
	a_two_minute: assert property (@(posedge clock) disable iff (!rst_n)
		sec_tick && alarm_two_minutes[MASK_BIT] &&
		alarm_two_hours[MASK_BIT] && alarm_two_day_date[MASK_BIT]
		|-> a2_hit == (next_seconds == BCD_ZERO))
		else $error("masked alarm two not tied to second zero");
	a_alarm_write: assert property (@(posedge clock) disable iff (!rst_n)
		wr_go && ptr == REG_A1_SEC |=> alarm_one_seconds == $past(wr_data))
		else $error("alarm one seconds write lost");
	a_seconds_bcd: assert property (@(posedge clock) disable iff (!rst_n)
		sec_tick && seconds_count == SEC_LAST |=> seconds_count == BCD_ZERO
		|| $past(wr_go))
		else $error("seconds did not roll 59 to 00");

endmodule : rtcam_regs

// [rtl/rtcam_pkg.sv]
// constants for the clock register map and alarm comparators
package rtcam_pkg;

	// ********************************************************
	// register offsets
	// ********************************************************
	localparam logic [7:0] REG_SECONDS   = 8'h00;
	localparam logic [7:0] REG_MINUTES   = 8'h01;
	localparam logic [7:0] REG_HOURS     = 8'h02;
	localparam logic [7:0] REG_WEEKDAY   = 8'h03;
	localparam logic [7:0] REG_MONTH_DAY = 8'h04;
	localparam logic [7:0] REG_MONTH_CEN = 8'h05;
	localparam logic [7:0] REG_YEAR      = 8'h06;
	localparam logic [7:0] REG_A1_SEC    = 8'h07;
	localparam logic [7:0] REG_A1_MIN    = 8'h08;
	localparam logic [7:0] REG_A1_HOUR   = 8'h09;
	localparam logic [7:0] REG_A1_DAY    = 8'h0a;
	localparam logic [7:0] REG_A2_MIN    = 8'h0b;
	localparam logic [7:0] REG_A2_HOUR   = 8'h0c;
	localparam logic [7:0] REG_A2_DAY    = 8'h0d;
	localparam logic [7:0] REG_CONTROL   = 8'h0e;
	localparam logic [7:0] REG_STATUS    = 8'h0f;
	localparam logic [7:0] REG_TRIM      = 8'h10;
	localparam logic [7:0] REG_TEMP_HIGH = 8'h11;
	localparam logic [7:0] REG_TEMP_LOW  = 8'h12;
	localparam logic [7:0] REG_TEST      = 8'h13;
	localparam logic [7:0] SRAM_BASE     = 8'h14;
	localparam logic [7:0] PTR_WRAP      = 8'h12;

	// ********************************************************
	// field positions
	// ********************************************************
	localparam int MASK_BIT     = 7;
	localparam int SELECT_BIT   = 6;
	localparam int MODE12_BIT   = 6;
	localparam int PM_BIT       = 5;
	localparam int CENTURY_BIT  = 7;
	localparam int CTRL_NOTWAVE = 2;
	localparam int CTRL_A2_IE   = 1;
	localparam int CTRL_A1_IE   = 0;
	localparam int STAT_OSC     = 7;
	localparam int STAT_A2_FLAG = 1;
	localparam int STAT_A1_FLAG = 0;
	localparam logic [7:0] STAT_KEEP = 8'h48;
	localparam logic [7:0] TEST_KEEP = 8'h80;
	localparam logic [7:0] TEMP_LOW_KEEP = 8'hc0;

	// ********************************************************
	// bcd limits
	// ********************************************************
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE  = 8'h01;
	localparam logic [7:0] SEC_LAST = 8'h59;
	localparam logic [7:0] H24_LAST = 8'h23;
	localparam logic [7:0] H12_ELEVEN = 8'h11;
	localparam logic [7:0] H12_TWELVE = 8'h12;
	localparam logic [7:0] WEEKDAY_LAST = 8'h07;
	localparam logic [7:0] MONTH_LAST = 8'h12;
	localparam logic [7:0] YEAR_LAST  = 8'h99;
	localparam logic [7:0] MON_FEB = 8'h02;
	localparam logic [7:0] MON_APR = 8'h04;
	localparam logic [7:0] MON_JUN = 8'h06;
	localparam logic [7:0] MON_SEP = 8'h09;
	localparam logic [7:0] MON_NOV = 8'h11;
	localparam logic [7:0] DAYS_28 = 8'h28;
	localparam logic [7:0] DAYS_29 = 8'h29;
	localparam logic [7:0] DAYS_30 = 8'h30;
	localparam logic [7:0] DAYS_31 = 8'h31;

	// ********************************************************
	// reset values
	// ********************************************************
	localparam logic [7:0] CONTROL_RST = 8'h1c;
	localparam logic [7:0] STATUS_RST  = 8'h00;
	localparam logic [7:0] HOURS_RST   = 8'h00;
	localparam logic [7:0] CLEAR_RST   = 8'h00;

endpackage : rtcam_pkg

// [rtl/rtcam_alarm_match.sv]
// masked bcd compare of one alarm against the updated time
`timescale 1ns/1ps
module rtcam_alarm_match
	import rtcam_pkg::*;
(
	// alarm setting, bit 7 of each byte masks the field
	input  wire logic [7:0] alarm_seconds,
	input  wire logic [7:0] alarm_minutes,
	input  wire logic [7:0] alarm_hours,
	input  wire logic [7:0] alarm_day_date,
	// time as it stands after the update
	input  wire logic [7:0] now_seconds,
	input  wire logic [7:0] now_minutes,
	input  wire logic [7:0] now_hours,
	input  wire logic [7:0] now_weekday,
	input  wire logic [7:0] now_month_day,
	// all unmasked fields equal
	output logic            hit
);

	// ********************************************************
	// field compare
	// ********************************************************
	logic sec_ok;  // seconds equal or masked
	logic min_ok;  // minutes equal or masked
	logic hour_ok; // hours equal, mode bit included
	logic day_ok;  // weekday or date equal

	// each mask bit removes its field from the compare
	always_comb begin
		sec_ok  = alarm_seconds[MASK_BIT] ||
			(alarm_seconds[6:0] == now_seconds[6:0]);
		min_ok  = alarm_minutes[MASK_BIT] ||
			(alarm_minutes[6:0] == now_minutes[6:0]);
		// the mode bit is part of the compare, so both must agree
		hour_ok = alarm_hours[MASK_BIT] ||
			(alarm_hours[6:0] == now_hours[6:0]);
		// select bit picks weekday (1) or date of month (0)
		if (alarm_day_date[SELECT_BIT]) begin
			day_ok = alarm_day_date[MASK_BIT] ||
				(alarm_day_date[5:0] == now_weekday[5:0]);
		end else begin
			day_ok = alarm_day_date[MASK_BIT] ||
				(alarm_day_date[5:0] == now_month_day[5:0]);
		end
		hit = sec_ok && min_ok && hour_ok && day_ok;
	end

endmodule : rtcam_alarm_match

// [testbench/rtcam_host.sv]
// host model that drives the register port one byte at a time
`timescale 1ns/1ps
module rtcam_host (
	// clock
	input  wire logic       clock,
	// register port
	output logic            ptr_load,
	output logic      [7:0] ptr_value,
	output logic            wr_strobe,
	output logic      [7:0] wr_data,
	output logic            rd_strobe,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid
);
	// ****************************************************
	// idle state at time zero
	// ****************************************************
	initial begin
		ptr_load = 1'b0;
		ptr_value = 8'h00;
		wr_strobe = 1'b0;
		wr_data = 8'h00;
		rd_strobe = 1'b0;
	end
	// point, then one write or read; idle data lines show the inverse
	// so a stale byte is never mistaken for fresh data
	task automatic access(input logic [7:0] a, input logic w,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clock);
		ptr_load <= 1'b1;
		ptr_value <= a;
		@(posedge clock);
		ptr_load <= 1'b0;
		ptr_value <= ~a;
		wr_strobe <= w;
		rd_strobe <= !w;
		wr_data <= d;
		@(posedge clock);
		wr_strobe <= 1'b0;
		rd_strobe <= 1'b0;
		wr_data <= ~d;
		#1;
		q = rd_valid === !w ? rd_data : ~rd_data;
	endtask : access
endmodule : rtcam_host

// [testbench/tb.sv]
// self-checking bench for the clock register map and alarms
`timescale 1ns/1ps
module tb;
	// ****************************************************
	// signals and scoreboard
	// ****************************************************
	logic       clock, rst_n, ce, osc_wave, ptr_load, wr_strobe;
	logic       rd_strobe, rd_valid, irq_wave_o, irq_wave_oe;
	logic [7:0] ptr_value, wr_data, rd_data, temp_high, temp_low, q;
	int         fails, num_checks;
	int         model [int]; // expected byte at each address
	rtcam_regs rtcam_regs_inst (.clock(clock), .rst_n(rst_n), .ce(ce),
		.osc_wave(osc_wave), .ptr_load(ptr_load), .ptr_value(ptr_value),
		.wr_strobe(wr_strobe), .wr_data(wr_data), .rd_strobe(rd_strobe),
		.rd_data(rd_data), .rd_valid(rd_valid), .temp_high(temp_high),
		.temp_low(temp_low), .irq_wave_o(irq_wave_o),
		.irq_wave_oe(irq_wave_oe));
	rtcam_host rtcam_host_inst (.clock(clock), .ptr_load(ptr_load),
		.ptr_value(ptr_value), .wr_strobe(wr_strobe), .wr_data(wr_data),
		.rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid));
	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// ****************************************************
	// tasks
	// ****************************************************
	task automatic chk(input string n, input logic [7:0] e, s);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		rtcam_host_inst.access(a, 1'b1, d, q);
		model[a] = d;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		rtcam_host_inst.access(a, 1'b0, 8'h00, q);
		chk("rd_data", model[a][7:0], q);
	endtask : rd
	// one rising edge of the one hertz wave, then let flags settle
	task automatic tick();
		@(posedge clock);
		osc_wave <= 1'b0;
		repeat (2) @(posedge clock);
		osc_wave <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
	endtask : tick
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : test_done
	// watchdog against a hung handshake
	initial begin
		repeat (5000) @(posedge clock);
		fails++;
		test_done();
	end
	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		fails = 0;
		num_checks = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		osc_wave = 1'b0;
		temp_high = 8'h00;
		temp_low = 8'h00;
		void'($urandom(83));
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		temp_high <= 8'($urandom);
		temp_low <= 8'($urandom);
		for (int a = 7; a < 14; a++) begin
			wr(8'(a), 8'($urandom));
		end
		for (int a = 7; a < 14; a++) begin
			rd(8'(a));
		end
		wr(8'h11, 8'h5a);
		model[17] = temp_high;
		model[18] = temp_low & 8'hc0;
		rd(8'h11);
		rd(8'h12);
		// seconds-only alarm one, fully masked alarm two
		wr(8'h00, 8'h58);
		wr(8'h07, 8'h59);
		for (int a = 8; a < 14; a++) begin
			wr(8'(a), 8'h80);
		end
		wr(8'h0e, 8'h05);
		wr(8'h0f, 8'h00);
		tick();
		model[0] = 8'h59;
		model[15] = 8'h01;
		rd(8'h00);
		rd(8'h0f);
		chk("irq_wave_oe", 8'h01, {7'h00, irq_wave_oe});
		chk("irq_wave_o", 8'h00, {7'h00, irq_wave_o});
		tick();
		model[0] = 8'h00;
		model[1] = 8'h01;
		model[15] = 8'h03;
		rd(8'h00);
		rd(8'h01);
		rd(8'h0f);
		// enables off: flags stay, pin released
		wr(8'h0e, 8'h04);
		repeat (2) @(posedge clock);
		#1;
		chk("irq_wave_oe", 8'h00, {7'h00, irq_wave_oe});
		rd(8'h0f);
		// no masks at 00:01:01: weekday select fires
		wr(8'h07, 8'h01);
		wr(8'h08, 8'h01);
		wr(8'h09, 8'h00);
		wr(8'h0a, 8'h41);
		wr(8'h0f, 8'h00);
		tick();
		model[15] = 8'h01;
		rd(8'h0f);
		// no masks at 00:01:02: date select with a wrong date stays quiet
		wr(8'h07, 8'h02);
		wr(8'h0a, 8'h02);
		wr(8'h0f, 8'h00);
		tick();
		model[15] = 8'h00;
		rd(8'h0f);
		// all four masks set: fires on any second
		for (int a = 7; a < 11; a++) begin
			wr(8'(a), 8'h80);
		end
		tick();
		model[15] = 8'h01;
		rd(8'h0f);
		// clock enable low: the wave edge is lost, time stands
		@(posedge clock);
		ce <= 1'b0;
		tick();
		@(posedge clock);
		ce <= 1'b1;
		model[0] = 8'h03;
		rd(8'h00);
		// wave mode: pin enable follows the inverse of the wave
		wr(8'h0e, 8'h00);
		@(posedge clock);
		osc_wave <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		chk("irq_wave_oe", 8'h01, {7'h00, irq_wave_oe});
		// general storage at the top of the map
		wr(8'hff, 8'($urandom));
		rd(8'hff);
		test_done();
	end
endmodule : tb
